/* File: rtl/ldq_quantizer.sv */
/*
  Log dimming quantizer: averages the host duty command, picks one of 16
  levels with hysteresis, generates the internal dimming pulse, gates the
  boost stage and channels, and latches per-channel faults.
  Assumes comparator flags for each channel sense pin and a reset that
  stands for a power cycle.
*/
`timescale 1ns/1ps
module ldq_quantizer
  import ldq_pkg::*;
#(
  parameter int WIN_BITS = WIN_BITS_DEF
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Host dimming inputs
  input wire logic dutyCmdIn,
  input wire logic rangeSelIn,
  input wire logic dimFreqSelDirect,
  input wire logic [7:0] dimRateCode,
  // Enable
  input wire logic enableIn,
  // Channel sense comparators
  input wire logic [NUM_CH-1:0] senseLowIn,
  input wire logic [NUM_CH-1:0] senseHighIn,
  // Drive outputs
  output logic dimRatioPulse,
  output logic boostSwitchEn,
  output logic feedbackGroundSwitch,
  output logic [NUM_CH-1:0] chanSinkEn,
  output logic [NUM_CH-1:0] chanSenseOe,
  // Status
  output logic [3:0] dimLevel,
  output logic [NUM_CH-1:0] chanFault
);
  typedef struct packed {
    logic [1:0] dutyS;
    logic [1:0] rangeS;
    logic [1:0] directS;
    logic [1:0] enS;
    logic [1:0][NUM_CH-1:0] lowS;
    logic [1:0][NUM_CH-1:0] highS;
    logic [9:0] avg;
    logic [3:0] level;
    logic [7:0] divCnt;
    logic [9:0] step;
    logic [9:0] dutyLatch;
    logic pulse;
    logic [NUM_CH-1:0] fault;
    logic [2:0] faultCnt;
  } ldq_state_t;

  ldq_state_t st_reg;
  ldq_state_t st_next;
  logic [SAMPLE_BITS-1:0] sample;
  logic sampleValid;
  logic [7:0] divSel;
  logic [9:0] nomVal;
  logic [9:0] upThr;
  logic [9:0] dnThr;
  logic signed [11:0] avgDiff;
  logic detectOk;
  logic taken;

  // ****************************************
  // Duty measurement
  // ****************************************
  ldq_duty_meter #(.WIN_BITS(WIN_BITS)) u_meter (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .dutyLvl(st_reg.dutyS[1]),
    .sample(sample),
    .sampleValid(sampleValid)
  );

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    st_next = st_reg;
    st_next.dutyS = {st_reg.dutyS[0], dutyCmdIn};
    st_next.rangeS = {st_reg.rangeS[0], rangeSelIn};
    st_next.directS = {st_reg.directS[0], dimFreqSelDirect};
    st_next.enS = {st_reg.enS[0], enableIn};
    st_next.lowS = {st_reg.lowS[0], senseLowIn};
    st_next.highS = {st_reg.highS[0], senseHighIn};
    // Averaging and level selection
    nomVal = 10'(st_reg.level) << LEVEL_SHIFT;
    upThr = nomVal + THR_CNT;
    dnThr = nomVal - LEVEL_STEP + THR_CNT - HYST_CNT;
    avgDiff = 12'(sample) - 12'(st_reg.avg);
    if (sampleValid) begin
      st_next.avg = st_reg.avg + 10'(avgDiff >>> AVG_SHIFT);
      if (st_reg.level != LEVEL_TOP && st_reg.avg > upThr) begin
        st_next.level = st_reg.level + 4'h1;
      end else if (st_reg.level != LEVEL_RST && st_reg.avg < dnThr) begin
        st_next.level = st_reg.level - 4'h1;
      end
    end
    // Dimming rate, clamped to the selected range
    if (st_reg.rangeS[1]) begin
      divSel = (dimRateCode < HF_DIV_MIN) ? HF_DIV_MIN :
               (dimRateCode > HF_DIV_MAX) ? HF_DIV_MAX : dimRateCode;
    end else begin
      divSel = (dimRateCode < LF_DIV_MIN) ? LF_DIV_MIN :
               (dimRateCode > LF_DIV_MAX) ? LF_DIV_MAX : dimRateCode;
    end
    if (st_reg.divCnt >= divSel - 8'h01) begin
      st_next.divCnt = 8'h00;
      if (st_reg.step >= STEP_LAST) begin
        st_next.step = 10'h000;
        st_next.dutyLatch = DR_TABLE[st_reg.level];
      end else begin
        st_next.step = st_reg.step + 10'h001;
      end
    end else begin
      st_next.divCnt = st_reg.divCnt + 8'h01;
    end
    if (st_reg.directS[1]) begin
      st_next.pulse = st_reg.rangeS[1];
    end else begin
      st_next.pulse = st_reg.step < st_reg.dutyLatch;
    end
    // Channel fault latches, one new fault per cycle
    detectOk = st_reg.enS[1] && st_reg.faultCnt < FAULT_LIMIT;
    taken = 1'b0;
    for (int i = 0; i < NUM_CH; i++) begin
      if (detectOk && !taken && !st_reg.fault[i] &&
          (st_reg.lowS[1][i] || st_reg.highS[1][i])) begin
        st_next.fault[i] = 1'b1;
        taken = 1'b1;
      end
    end
    if (taken) begin
      st_next.faultCnt = st_reg.faultCnt + 3'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign dimRatioPulse = st_reg.pulse;
  assign boostSwitchEn = st_reg.enS[1] && st_reg.pulse;
  assign feedbackGroundSwitch = st_reg.enS[1];
  assign chanSinkEn = {NUM_CH{boostSwitchEn}} & ~st_reg.fault;
  assign chanSenseOe = {NUM_CH{st_reg.enS[1]}} & ~st_reg.fault;
  assign dimLevel = st_reg.level;
  assign chanFault = st_reg.fault;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  a_boost_gate: assert property (boostSwitchEn |-> dimRatioPulse && enableIn ||
      dimRatioPulse && $past(enableIn, 2))
    else $error("boost switching outside dimming pulse");
  a_shutdown_off: assert property (!st_reg.enS[1] |->
      !feedbackGroundSwitch && !boostSwitchEn && chanSinkEn == '0)
    else $error("outputs active while disabled");
  a_fbsw_follow: assert property ($rose(enableIn) |-> ##2 feedbackGroundSwitch)
    else $error("feedback ground switch not closed after enable");
  a_fault_sticky: assert property ((st_reg.fault & ~$past(st_reg.fault)) == '0 ||
      (~st_reg.fault & $past(st_reg.fault)) == '0)
    else $error("fault latch set and cleared together");
  a_fault_hold: assert property (($past(st_reg.fault) & ~st_reg.fault) == '0)
    else $error("fault latch cleared during operation");
  a_fault_limit: assert property ($countones(st_reg.fault) <= 4)
    else $error("more than four channels faulted");
  a_fault_cause: assert property (st_reg.fault != $past(st_reg.fault) |->
      $past(st_reg.enS[1]) && ((($past(st_reg.lowS[1]) | $past(st_reg.highS[1])) &
      st_reg.fault & ~$past(st_reg.fault)) != '0))
    else $error("fault latched without comparator cause");
  a_fault_release: assert property (st_reg.fault != '0 |->
      ((chanSenseOe | chanSinkEn) & st_reg.fault) == '0)
    else $error("faulted channel still driving");
  a_direct_path: assert property (st_reg.directS[1] |=>
      dimRatioPulse == $past(st_reg.rangeS[1]))
    else $error("direct mode pulse not passed through");
  a_level_up: assert property (st_reg.level > $past(st_reg.level) |->
      $past(st_reg.avg) > $past(upThr) && st_reg.level == $past(st_reg.level) + 4'h1)
    else $error("level rose without crossing threshold");
  a_level_down: assert property (st_reg.level < $past(st_reg.level) |->
      $past(st_reg.avg) < $past(dnThr) && st_reg.level == $past(st_reg.level) - 4'h1)
    else $error("level fell without crossing threshold");
  a_hyst_gap: assert property (st_reg.level < $past(st_reg.level) |->
      int'($past(st_reg.avg)) + int'(HYST_CNT) <
      int'(st_reg.level) * int'(LEVEL_STEP) + int'(THR_CNT))
    else $error("level fell inside hysteresis band");
  a_level_zero: assert property (!st_reg.directS[1] && st_reg.dutyLatch == '0 |=>
      !dimRatioPulse)
    else $error("pulse high at zero duty");
  a_range_clamp: assert property (st_reg.rangeS[1] ?
      (divSel >= HF_DIV_MIN && divSel <= HF_DIV_MAX) :
      (divSel >= LF_DIV_MIN && divSel <= LF_DIV_MAX))
    else $error("dimming divisor out of range");

  c_level_top: cover property (st_reg.level == LEVEL_TOP);
  c_four_faults: cover property (st_reg.faultCnt == FAULT_LIMIT);
  c_direct_pulse: cover property (st_reg.directS[1] && $rose(dimRatioPulse));
  c_boost_on: cover property ($rose(boostSwitchEn) && st_reg.level != 4'h0);
endmodule

/* File: pkg/ldq_pkg.sv */
/*
  Constants shared by the log dimming quantizer and its duty meter.
  Assumes a 25 MHz sampling clock.
*/
package ldq_pkg;
  // ****************************************
  // Clock, channels, dimming period
  // ****************************************
  localparam int CLK_HZ = 25_000_000;
  localparam int NUM_CH = 6;
  localparam int DUTY_STEPS = 1000;
  localparam logic [9:0] STEP_LAST = 10'(DUTY_STEPS - 1);
  // ****************************************
  // Dimming frequency ranges and divisors
  // ****************************************
  localparam int LF_MIN_HZ = 100;
  localparam int LF_MAX_HZ = 2000;
  localparam int HF_MIN_HZ = 1500;
  localparam int HF_MAX_HZ = 20000;
  // Smallest divisors round up so the fastest rate stays inside its range
  localparam logic [7:0] LF_DIV_MIN =
    8'((CLK_HZ + LF_MAX_HZ * DUTY_STEPS - 1) / (LF_MAX_HZ * DUTY_STEPS));
  localparam logic [7:0] LF_DIV_MAX = 8'(CLK_HZ / (LF_MIN_HZ * DUTY_STEPS));
  localparam logic [7:0] HF_DIV_MIN =
    8'((CLK_HZ + HF_MAX_HZ * DUTY_STEPS - 1) / (HF_MAX_HZ * DUTY_STEPS));
  localparam logic [7:0] HF_DIV_MAX = 8'(CLK_HZ / (HF_MIN_HZ * DUTY_STEPS));
  // ****************************************
  // Duty measurement and level thresholds
  // ****************************************
  localparam int SAMPLE_BITS = 10;
  localparam int WIN_BITS_DEF = 18;
  localparam int AVG_SHIFT = 2;
  localparam int LEVEL_SHIFT = 6;
  localparam logic [9:0] LEVEL_STEP = 10'h040;
  localparam logic [3:0] LEVEL_TOP = 4'hF;
  localparam int THR_BP = 416;
  localparam int HYST_BP = 200;
  localparam logic [9:0] THR_CNT = 10'(THR_BP * 1024 / 10000);
  localparam logic [9:0] HYST_CNT = 10'(HYST_BP * 1024 / 10000);
  localparam logic [9:0] SAMPLE_MAX = 10'h3FF;
  // ****************************************
  // Output duty per level, in steps of 0.1 percent
  // ****************************************
  localparam logic [9:0] DR_TABLE [16] = '{
    10'h000, 10'h00A, 10'h00E, 10'h013, 10'h01B, 10'h025, 10'h034, 10'h048,
    10'h064, 10'h08C, 10'h0BE, 10'h10E, 10'h172, 10'h208, 10'h2D0, 10'h3E8};
  // ****************************************
  // Reset values and fault limit
  // ****************************************
  localparam logic [3:0] LEVEL_RST = 4'h0;
  localparam logic [9:0] AVG_RST = 10'h000;
  localparam logic [2:0] FAULT_LIMIT = 3'h4;
endpackage

/* File: rtl/ldq_duty_meter.sv */
/*
  Duty meter: counts high and total time of the synchronised duty command
  over a fixed window and reports the high fraction on a 1024 scale.
  Assumes its input is already synchronised to sys_clk.
*/
`timescale 1ns/1ps
module ldq_duty_meter
  import ldq_pkg::*;
#(
  parameter int WIN_BITS = WIN_BITS_DEF
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Duty command level
  input wire logic dutyLvl,
  // Measured duty
  output logic [SAMPLE_BITS-1:0] sample,
  output logic sampleValid
);
  typedef struct packed {
    logic [WIN_BITS-1:0] winCnt;
    logic [WIN_BITS:0] highCnt;
    logic [SAMPLE_BITS-1:0] sample;
    logic valid;
  } ldq_meter_t;

  ldq_meter_t st_reg;
  ldq_meter_t st_next;
  logic [WIN_BITS:0] highSum;

  // ****************************************
  // Window counting
  // ****************************************
  always_comb begin
    st_next = st_reg;
    highSum = st_reg.highCnt + (WIN_BITS+1)'(dutyLvl);
    st_next.winCnt = st_reg.winCnt + 1'b1;
    st_next.valid = 1'b0;
    st_next.highCnt = highSum;
    if (&st_reg.winCnt) begin
      st_next.valid = 1'b1;
      st_next.highCnt = '0;
      if (highSum[WIN_BITS]) begin
        st_next.sample = SAMPLE_MAX;
      end else begin
        st_next.sample = highSum[WIN_BITS-1 -: SAMPLE_BITS];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sample = st_reg.sample;
  assign sampleValid = st_reg.valid;

  // ****************************************
  // Checks
  // ****************************************
  a_window_period: assert property (@(posedge sys_clk) disable iff (!rst_b)
    sampleValid |=> !sampleValid [*8])
    else $error("duty sample issued twice within one window");
  a_window_align: assert property (@(posedge sys_clk) disable iff (!rst_b)
    sampleValid |-> st_reg.winCnt == '0 && st_reg.highCnt == '0)
    else $error("duty sample not aligned to window start");
endmodule

/* File: test/ldq_host_model.sv */
/*
  Host dimming source: drives the duty command pin with a fixed
  1024-cycle period and a settable high time.
  Assumes a 25 MHz sys_clk; the pulses run from time zero.
*/
`timescale 1ns/1ps
module ldq_host_model (
  // Clock
  input wire logic sys_clk,
  // High cycles per period
  input wire logic [9:0] hiCycles,
  // Duty command pin
  output logic dutyCmdIn
);
  logic [9:0] phaseReg = 10'h000;
  // 24.4 kHz command, running before enable is raised
  always @(posedge sys_clk) begin
    phaseReg <= phaseReg + 10'h001;
    dutyCmdIn <= (phaseReg < hiCycles);
  end
endmodule

/* File: test/log_dimming_quantizer_bench.sv */
/*
  Self-checking bench for ldq_quantizer with a short duty window.
  Assumes the host model in ldq_host_model.sv.
*/
`timescale 1ns/1ps
module log_dimming_quantizer_bench;
  import ldq_pkg::*;
  localparam int WB = 10;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic rangeSelIn = 1'b1;
  logic dimFreqSelDirect = 1'b0;
  logic [7:0] dimRateCode = 8'h01;
  logic enableIn = 1'b0;
  logic [NUM_CH-1:0] senseLowIn = '0;
  logic [NUM_CH-1:0] senseHighIn = '0;
  logic [9:0] hiCycles = 10'h000;
  logic dutyCmdIn, dimRatioPulse, boostSwitchEn, feedbackGroundSwitch;
  logic [NUM_CH-1:0] chanSinkEn, chanSenseOe, chanFault;
  logic [3:0] dimLevel;
  logic [2:0] hist;
  int n_mismatch = 0;
  int total_checks = 0;
  int lvl;
  int chOrd [6] = '{1, 4, 0, 2, 3, 5};
  logic [5:0] masks [6] = '{6'h02, 6'h12, 6'h13, 6'h17, 6'h17, 6'h17};
  always #20 sys_clk = ~sys_clk;
  ldq_host_model host (.sys_clk(sys_clk), .hiCycles(hiCycles), .dutyCmdIn(dutyCmdIn));
  ldq_quantizer #(.WIN_BITS(WB)) uut (.sys_clk(sys_clk), .rst_b(rst_b),
    .dutyCmdIn(dutyCmdIn), .rangeSelIn(rangeSelIn), .dimFreqSelDirect(dimFreqSelDirect),
    .dimRateCode(dimRateCode), .enableIn(enableIn), .senseLowIn(senseLowIn),
    .senseHighIn(senseHighIn), .dimRatioPulse(dimRatioPulse), .boostSwitchEn(boostSwitchEn),
    .feedbackGroundSwitch(feedbackGroundSwitch), .chanSinkEn(chanSinkEn),
    .chanSenseOe(chanSenseOe), .dimLevel(dimLevel), .chanFault(chanFault));
  // ****************************************
  // Checking and expectations
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    if (n_mismatch == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  function automatic int expLevel(int s);
    int n = 0;
    for (int k = 1; k < 16; k++) if (s > (k - 1) * 64 + 42) n = k;
    return n;
  endfunction
  function automatic int expHigh(int n, int div);
    int pm [16] = '{0, 10, 14, 19, 27, 37, 52, 72, 100, 140, 190, 270, 370, 520, 720, 1000};
    return pm[n] * div;
  endfunction
  // ****************************************
  // Stimulus tasks
  // ****************************************
  task automatic cyc(int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic waitLevel(int s);
    hiCycles <= 10'(s);
    lvl = expLevel(s);
    for (int w = 0; w < 40 && dimLevel !== 4'(lvl); w++) cyc(1 << WB);
    if (dimLevel !== 4'(lvl)) begin
      check(32'(dimLevel), 32'(lvl));
      conclude();
    end
    cyc(2 << WB);
    check(32'(dimLevel), 32'(lvl));
  endtask
  task automatic checkPulse(int div);
    int hi = 0;
    int bs = 0;
    cyc(1000 * div + 8);
    repeat (1000 * div) begin
      @(negedge sys_clk);
      hi += (dimRatioPulse === 1'b1);
      bs += (boostSwitchEn === 1'b1);
    end
    check(32'(hi), 32'(expHigh(lvl, div)));
    check(32'(bs), 32'(expHigh(lvl, div)));
  endtask
  task automatic hitChan(input logic hiSide, input int ch, input logic [5:0] expMask);
    @(posedge sys_clk);
    if (hiSide) senseHighIn[ch] <= 1'b1;
    else senseLowIn[ch] <= 1'b1;
    @(posedge sys_clk);
    senseHighIn <= '0;
    senseLowIn <= '0;
    repeat (4) @(negedge sys_clk);
    check(32'(chanFault), 32'(expMask));
    check(32'(chanSenseOe), 32'(expMask ^ 6'h3F));
    // Level 15 keeps the dimming pulse high, so every healthy channel sinks
    check(32'(chanSinkEn), 32'(expMask ^ 6'h3F));
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(12));
    cyc(9);
    @(negedge sys_clk);
    check(32'({dimRatioPulse, boostSwitchEn, feedbackGroundSwitch, chanSinkEn,
      chanSenseOe, dimLevel, chanFault}), 32'h0);
    @(posedge sys_clk);
    rst_b <= 1'b1;
    cyc(4);
    enableIn <= 1'b1;
    @(negedge sys_clk);
    check(32'(feedbackGroundSwitch), 32'h0);
    repeat (3) @(negedge sys_clk);
    check(32'({feedbackGroundSwitch, chanSenseOe}), 32'h7F);
    @(posedge sys_clk);
    waitLevel(64 * int'(1 + $urandom % 14) + int'($urandom % 21) - 10);
    // Rate code 1 lies below the high range and clamps to its fastest divisor
    checkPulse(int'(HF_DIV_MIN));
    waitLevel(1000);
    checkPulse(int'(HF_DIV_MIN));
    for (int i = 0; i < 6; i++) hitChan(i[0], chOrd[i], masks[i]);
    @(posedge sys_clk);
    hiCycles <= 10'(926);
    cyc(12 << WB);
    check(32'(dimLevel), 32'hF);
    waitLevel(64 * int'(1 + $urandom % 14) + int'($urandom % 21) - 10);
    rangeSelIn <= 1'b0;
    dimRateCode <= 8'h05;
    // Rate code 5 lies below the low range and clamps to its fastest divisor
    checkPulse(int'(LF_DIV_MIN));
    @(posedge sys_clk);
    dimFreqSelDirect <= 1'b1;
    cyc(6);
    hist = {3{rangeSelIn}};
    repeat (60) begin
      @(posedge sys_clk);
      rangeSelIn <= 1'($urandom % 2);
      @(negedge sys_clk);
      check(32'(dimRatioPulse), 32'(hist[2]));
      hist = {hist[1:0], rangeSelIn};
    end
    @(posedge sys_clk);
    enableIn <= 1'b0;
    repeat (4) @(negedge sys_clk);
    check(32'({feedbackGroundSwitch, boostSwitchEn, chanSenseOe}), 32'h0);
    check(32'(chanFault), 32'h17);
    @(posedge sys_clk);
    rst_b <= 1'b0;
    cyc(2);
    rst_b <= 1'b1;
    @(negedge sys_clk);
    check(32'({chanFault, dimLevel}), 32'h0);
    conclude();
  end
endmodule
